// *** dspac_pkg.sv ***
// Purpose: Shared constants for the slice add and carry path.
// Assumes: Operation select word is eight bits wide.
// Notes:   Widths, field positions, multiplexer codes and reset values.
package dspac_pkg;
  localparam int OP_W          = 8;
  localparam int DATA_W        = 18;
  localparam int PROD_W        = 36;
  localparam int SUM_W         = 48;
  localparam int D_LOW_W       = 12;
  localparam int OP_POST_SUB   = 7;
  localparam int OP_PRE_SUB    = 6;
  localparam int OP_CARRY      = 5;
  localparam int OP_PRE_USE    = 4;
  localparam logic [1:0] X_ZERO   = 2'h0;
  localparam logic [1:0] X_PROD   = 2'h1;
  localparam logic [1:0] X_RESULT = 2'h2;
  localparam logic [1:0] X_CONCAT = 2'h3;
  localparam logic [1:0] Z_ZERO   = 2'h0;
  localparam logic [1:0] Z_CASC   = 2'h1;
  localparam logic [1:0] Z_RESULT = 2'h2;
  localparam logic [1:0] Z_C      = 2'h3;
  localparam logic [SUM_W-1:0] RESULT_RESET = 48'h000000000000;
  localparam logic             CARRY_RESET  = 1'h0;
endpackage : dspac_pkg

// *** dspac_core.sv ***
// Purpose: Pre-adder, X and Z multiplexers, post-adder and carry selection.
// Assumes: One clock, synchronous active-high reset; multiplier is combinational.
// Notes:   The result register feeds both the result and the cascade output.
// Operation
// - Pre-adder gives D minus or plus B
// - Bit seven selects post-adder subtraction
// - X plus carry, then added to Z
// - Low four bits pick X and Z
// - Carry from upstream or operation bit five
// - Optional carry register delays the carry by one clock
// - All-ones mode subtracts concatenation with pre-adder from C
// - Pre-subtract multiply added to C input
// - Word 00000001 loads product into result
// - Word 00001001 accumulates product each clock
// - Word 00000101 adds product to cascade
// - Pre-adder and post-adder combine three inputs
// - X select: zero, product, result, concatenation
// - Z select: zero, cascade, result, C
// - Bit four routes pre-adder in place of B
// - Product sign-extended to 48 bits
`timescale 1ns/10ps
module dspac_core (
  input  wire logic                          clock,
  input  wire logic                          sys_rst,
  input  wire logic [dspac_pkg::OP_W-1:0]    operation_select,
  input  wire logic                          carry_source_select,
  input  wire logic                          carry_register_cfg,
  input  wire logic                          carry_in_upstream,
  input  wire logic [dspac_pkg::DATA_W-1:0]  a_in,
  input  wire logic [dspac_pkg::DATA_W-1:0]  b_in,
  input  wire logic [dspac_pkg::DATA_W-1:0]  d_in,
  input  wire logic [dspac_pkg::SUM_W-1:0]   c_in,
  input  wire logic [dspac_pkg::SUM_W-1:0]   cascade_sum_in,
  output logic      [dspac_pkg::SUM_W-1:0]   result,
  output logic      [dspac_pkg::SUM_W-1:0]   cascade_sum_out,
  output logic      [dspac_pkg::DATA_W-1:0]  pre_adder_out
);
  import dspac_pkg::*;

  // Both operands are widened to the product width before multiplying, so no product bit is lost.
  function automatic logic [PROD_W-1:0] mult_signed(input logic [DATA_W-1:0] lhs,
                                                    input logic [DATA_W-1:0] rhs);
    logic signed [PROD_W-1:0] lhs_wide;
    logic signed [PROD_W-1:0] rhs_wide;
    lhs_wide    = {{(PROD_W-DATA_W){lhs[DATA_W-1]}}, lhs};
    rhs_wide    = {{(PROD_W-DATA_W){rhs[DATA_W-1]}}, rhs};
    mult_signed = lhs_wide * rhs_wide;
  endfunction : mult_signed

  // Copies the product sign bit up to the post-adder width.
  function automatic logic [SUM_W-1:0] widen_product(input logic [PROD_W-1:0] prod);
    widen_product = {{(SUM_W-PROD_W){prod[PROD_W-1]}}, prod};
  endfunction : widen_product

  logic [DATA_W-1:0] pre_sum;
  logic [DATA_W-1:0] b_sel;
  logic [PROD_W-1:0] product;
  logic [SUM_W-1:0]  x_mux;
  logic [SUM_W-1:0]  z_mux;
  logic              carry_sel;
  logic              carry_reg;
  logic              carry_used;
  logic [SUM_W-1:0]  x_plus_carry;
  logic [SUM_W-1:0]  next_result;
  logic [SUM_W-1:0]  result_reg;

  // Pre-adder on D and B, also usable with the post-adder in one pass.
  assign pre_sum = operation_select[OP_PRE_SUB] ? (d_in - b_in) : (d_in + b_in);
  assign b_sel   = operation_select[OP_PRE_USE] ? pre_sum : b_in;
  assign product = mult_signed(a_in, b_sel);

  always_comb begin
    case (operation_select[1:0])
      X_ZERO:   x_mux = '0;
      X_PROD:   x_mux = widen_product(product);
      X_RESULT: x_mux = result_reg;
      default:  x_mux = {d_in[D_LOW_W-1:0], a_in, b_sel};
    endcase
  end

  always_comb begin
    case (operation_select[3:2])
      Z_ZERO:   z_mux = '0;
      Z_CASC:   z_mux = cascade_sum_in;
      Z_RESULT: z_mux = result_reg;
      default:  z_mux = c_in;
    endcase
  end

  assign carry_sel = carry_source_select ? operation_select[OP_CARRY] : carry_in_upstream;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      carry_reg <= CARRY_RESET;
    end else begin
      carry_reg <= carry_sel;
    end
  end

  assign carry_used   = carry_register_cfg ? carry_reg : carry_sel;
  assign x_plus_carry = x_mux + SUM_W'(carry_used);
  assign next_result  = operation_select[OP_POST_SUB] ? (z_mux - x_plus_carry) : (z_mux + x_plus_carry);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      result_reg <= RESULT_RESET;
    end else begin
      result_reg <= next_result;
    end
  end

  assign result          = result_reg;
  assign cascade_sum_out = result_reg;
  assign pre_adder_out   = pre_sum;

  // Each mode word is judged at the edge after it is applied, against the operands it saw.
  // Sums are rebuilt from the inputs, or checked through the inverse operation.

  sequence s_load_word;
    operation_select == 8'h01;
  endsequence

  sequence s_acc_word;
    operation_select == 8'h09;
  endsequence

  sequence s_casc_word;
    operation_select == 8'h05;
  endsequence

  sequence s_c_word;
    operation_select == 8'h0C;
  endsequence

  // The check waits for the carry register to be selected on two edges in a row; its delay shows from the first.
  sequence s_carry_reg_held;
    carry_register_cfg ##1 carry_register_cfg;
  endsequence

  property p_load;
    @(posedge clock) disable iff (sys_rst)
      s_load_word |=>
        result == widen_product(mult_signed($past(a_in), $past(b_in)))
                  + SUM_W'($past(carry_used));
  endproperty
  a_load: assert property (p_load)
    else $error("Load word did not place the product alone in the result.");

  property p_accumulate;
    @(posedge clock) disable iff (sys_rst)
      s_acc_word |=>
        result == $past(result) + widen_product(mult_signed($past(a_in), $past(b_in)))
                  + SUM_W'($past(carry_used));
  endproperty
  a_accumulate: assert property (p_accumulate)
    else $error("Accumulate word did not add the product to the result.");

  property p_cascade_add;
    @(posedge clock) disable iff (sys_rst)
      s_casc_word |=>
        result == $past(cascade_sum_in) + widen_product(mult_signed($past(a_in), $past(b_in)))
                  + SUM_W'($past(carry_used));
  endproperty
  a_cascade_add: assert property (p_cascade_add)
    else $error("Cascade word did not add the product to the cascaded sum.");

  property p_c_select;
    @(posedge clock) disable iff (sys_rst)
      s_c_word |=> result == $past(c_in) + SUM_W'($past(carry_used));
  endproperty
  a_c_select: assert property (p_c_select)
    else $error("C select word did not pass the C input to the result.");

  property p_pre_sub;
    @(posedge clock) disable iff (sys_rst)
      operation_select[OP_PRE_SUB] |-> DATA_W'(pre_adder_out + b_in) == d_in;
  endproperty
  a_pre_sub: assert property (p_pre_sub)
    else $error("Pre-adder did not give D minus B.");

  property p_pre_add;
    @(posedge clock) disable iff (sys_rst)
      !operation_select[OP_PRE_SUB] |-> DATA_W'(pre_adder_out - b_in) == d_in;
  endproperty
  a_pre_add: assert property (p_pre_add)
    else $error("Pre-adder did not give D plus B.");

  property p_post_sub;
    @(posedge clock) disable iff (sys_rst)
      operation_select[OP_POST_SUB] |=>
        SUM_W'(result + $past(x_mux) + SUM_W'($past(carry_used))) == $past(z_mux);
  endproperty
  a_post_sub: assert property (p_post_sub)
    else $error("Post-adder did not subtract X and carry from Z.");

  property p_post_add;
    @(posedge clock) disable iff (sys_rst)
      !operation_select[OP_POST_SUB] |=>
        SUM_W'(result - $past(x_mux) - SUM_W'($past(carry_used))) == $past(z_mux);
  endproperty
  a_post_add: assert property (p_post_add)
    else $error("Post-adder did not add X and carry to Z.");

  property p_carry_upstream;
    @(posedge clock) disable iff (sys_rst)
      !carry_source_select |-> carry_sel == carry_in_upstream;
  endproperty
  a_carry_upstream: assert property (p_carry_upstream)
    else $error("Carry was not taken from the upstream slice.");

  property p_carry_user;
    @(posedge clock) disable iff (sys_rst)
      carry_source_select |-> carry_sel == operation_select[OP_CARRY];
  endproperty
  a_carry_user: assert property (p_carry_user)
    else $error("Carry was not taken from the operation select word.");

  property p_carry_reg;
    @(posedge clock) disable iff (sys_rst)
      s_carry_reg_held |-> carry_used == $past(carry_sel);
  endproperty
  a_carry_reg: assert property (p_carry_reg)
    else $error("Registered carry was not delayed by one clock.");

  property p_result_out;
    @(posedge clock) disable iff (sys_rst)
      1'b1 |=> result == $past(next_result) && cascade_sum_out == $past(next_result);
  endproperty
  a_result_out: assert property (p_result_out)
    else $error("Result or cascade output did not show the registered sum.");
endmodule : dspac_core

// *** dspac_nbr.sv ***
// Purpose: Upstream slice model driving cascade sum and carry.
// Assumes: Bench sets the values; outputs are registered.
// Notes:   Outputs change only after a clock edge.
`timescale 1ns/10ps
module dspac_nbr (
  input  wire logic        clock,
  input  wire logic [47:0] sum_set,
  input  wire logic        carry_set,
  output logic      [47:0] sum_out,
  output logic             carry_out
);
  always_ff @(posedge clock) begin
    sum_out   <= sum_set;
    carry_out <= carry_set;
  end
endmodule : dspac_nbr

// *** dspac_core_bench.sv ***
// Purpose: Self-checking bench for the slice add and carry path.
// Assumes: A=2, B=3, D=5, C=0x10, cascade sum 0x100.
// Notes:   Rows run back to back; the carry path is tested by hand.
`timescale 1ns/10ps
module dspac_core_bench;
  import dspac_pkg::*;
  logic        clock = 0, sys_rst = 1, sel = 1, creg = 0, cset = 0, cup;
  logic [7:0]  op = 8'h00;
  logic [47:0] result, casc, res_o;
  logic [17:0] a_v = 18'h00002, b_v = 18'h00003, d_v = 18'h00005, pre_o;
  logic [47:0] c_v = 48'h000000000010;
  int          n_fail = 0, checks_done = 0, cyc = 0;
  logic [7:0]  ops [8] = '{8'h01, 8'h09, 8'h05, 8'h3D, 8'h7D, 8'h9F, 8'h8A, 8'hA0};
  logic [47:0] exps [8] = '{48'h6, 48'hC, 48'h106, 48'h21, 48'h15, 48'hFFAFFFF80008, 48'h0, 48'hFFFFFFFFFFFF};
  logic [17:0] pres [8] = '{18'h00008, 18'h00008, 18'h00008, 18'h00008, 18'h00002, 18'h00008, 18'h00008, 18'h00008};
  dspac_nbr nbr (.clock(clock), .sum_set(48'h100), .carry_set(cset), .sum_out(casc), .carry_out(cup));
  dspac_core uut (.clock(clock), .sys_rst(sys_rst), .operation_select(op), .carry_source_select(sel),
    .carry_register_cfg(creg), .carry_in_upstream(cup), .a_in(a_v), .b_in(b_v), .d_in(d_v),
    .c_in(c_v), .cascade_sum_in(casc), .result(result), .cascade_sum_out(res_o), .pre_adder_out(pre_o));
  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  initial begin
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc > 100) begin
      n_fail++;
      report_and_stop;
    end
  end
  initial begin
    repeat (12) @(posedge clock);
    #1 sys_rst = 0;
    for (int i = 0; i < 8; i++) begin
      op = ops[i];
      @(posedge clock);
      #1 chk("result", result, exps[i]);
      chk("cascade_out", res_o, exps[i]);
      chk("pre_adder", {30'h0, pre_o}, {30'h0, pres[i]});
      $display("row %0d done", i);
    end
    op = 8'h00;
    sel = 0;
    creg = 0;
    cset = 1;
    repeat (2) @(posedge clock);
    #1 chk("carry_upstream", result, 48'h000000000001);
    creg = 1;
    cset = 0;
    repeat (2) @(posedge clock);
    #1 chk("carry_reg_held", result, 48'h000000000001);
    @(posedge clock);
    #1 chk("carry_reg_clear", result, 48'h000000000000);
    $display("carry test done");
    creg = 0;
    sel = 1;
    a_v = 18'h00003;
    b_v = 18'h1FFFF;
    op = 8'h01;
    @(posedge clock);
    #1 chk("low_partial", result, 48'h00000005FFFD);
    c_v = {{17{result[47]}}, result[47:17]};
    b_v = 18'h00001;
    op = 8'h0D;
    @(posedge clock);
    #1 chk("high_partial", result, 48'h000000000005);
    a_v = 18'h3FFFF;
    b_v = 18'h00002;
    op = 8'h01;
    @(posedge clock);
    #1 chk("negative_product", result, 48'hFFFFFFFFFFFE);
    $display("wide multiply test done");
    c_v = 48'h000000000010;
    op = 8'h0C;
    @(posedge clock);
    #1 chk("c_select", result, 48'h000000000010);
    sys_rst = 1;
    @(posedge clock);
    #1 chk("reset", result, RESULT_RESET);
    sys_rst = 0;
    @(posedge clock);
    #1 chk("after_reset", result, 48'h000000000010);
    $display("reset test done");
    report_and_stop;
  end
endmodule : dspac_core_bench
